// *** common/dll_ctrl_pkg.sv ***
// Shared constants for the DAC clock delay-locked loop controller
package dll_ctrl_pkg;

	// ==============================================
	// Register port geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// ==============================================
	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_HYS_HI = 12'h088;
	localparam logic [ADDR_W-1:0] ADDR_HYS_LO = 12'h089;
	localparam logic [ADDR_W-1:0] ADDR_PWR = 12'h090;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h091;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h092;
	localparam logic [ADDR_W-1:0] ADDR_GUARD = 12'h093;
	localparam logic [ADDR_W-1:0] ADDR_COARSE = 12'h094;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h0A0;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h0A1;

	// ==============================================
	// Field positions
	localparam int PWR_PD_BIT = 0;
	localparam int COARSE_XC_BIT = 1;
	localparam int COARSE_DC_BIT = 2;
	localparam int FINE_XC_BIT = 3;
	localparam int FINE_DC_BIT = 4;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_SEARCH_LSB = 3;
	localparam int CTRL_SLOPE_BIT = 5;
	localparam int CTRL_SEARCH_ERR_BIT = 6;
	localparam int CTRL_TRACK_ERR_BIT = 7;
	localparam int STAT_LOCKED_BIT = 0;
	localparam int STAT_LOST_BIT = 1;
	localparam int STAT_FAIL_BIT = 2;
	localparam int IRQ_LOCK_BIT = 0;
	localparam int IRQ_LOST_BIT = 1;
	localparam int IRQ_FAIL_BIT = 2;
	localparam int HYS_W = 10;
	localparam int HYS_STEP_MV = 10;

	// ==============================================
	// Reset values
	localparam logic [4:0] PWR_RST = 5'h1F;
	localparam logic [7:0] CTRL_RST = 8'hF0;
	localparam logic [7:0] FINE_STATIC_DEFAULT = 8'h80;

	// ==============================================
	// Field encodings and limits
	localparam logic [1:0] MODE_SEARCH_TRACK = 2'h0;
	localparam logic [1:0] MODE_TRACK_ONLY = 2'h1;
	localparam logic [1:0] MODE_SEARCH_ONLY = 2'h2;
	localparam logic [1:0] SEARCH_DOWN = 2'h0;
	localparam logic [1:0] SEARCH_BOTH = 2'h2;
	localparam logic [5:0] COARSE_MAX = 6'h3F;
	localparam logic [7:0] FINE_MAX = 8'hFF;
	localparam logic [7:0] FINE_MIN = 8'h00;

	// ==============================================
	// Timing
	localparam int SETTLE_CYCLES_DEFAULT = 16;

	// Controller states
	typedef enum logic [2:0] {
		LS_IDLE,
		LS_SETTLE,
		LS_TRACK,
		LS_HOLD,
		LS_HALT
	} loop_state_e;

endpackage

// *** src/dll_sync2.sv ***
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module dll_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Level in and out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ==============================================
	// State
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_s;

	sync_s cur_r;
	sync_s cur_nxt;

	// First stage only feeds the second, to contain metastability
	always_comb begin
		cur_nxt.s1 = async_in;
		cur_nxt.s2 = cur_r.s1;
	end

	// Register the stages
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cur_r <= '0;
		end else if (clk_en) begin
			cur_r <= cur_nxt;
		end
	end

	assign sync_out = cur_r.s2;

endmodule

// *** src/dll_clock_ctrl.sv ***
// Register file and search/track controller of the DAC clock delay-locked loop
// Behaviour
// - A 10-bit receiver hysteresis code, bits 9:8 and 7:0 in two registers, each set bit adding 10 mV.
// - The power-down bit, reset to one, powers down the loop and the digital clock generator.
// - Bit 4 enables fine-line and bit 2 coarse-line duty-cycle correction, both reset to one.
// - Bit 3 enables fine-line and bit 1 coarse-line cross control, both reset to one.
// - Search direction 00 searches only downward, 10 both ways from the start point, reset 10.
// - Controller enable one runs the feedback loop, zero holds the static setpoints, reset zero.
// - Read-only status bit 2 flags that the loop failed to lock, reset zero.
// - Status bit 1 flags that a held lock was lost, is cleared by software writing one, reset zero.
// - Read-only status bit 0 reports that the loop is locked, reset zero.
// - A six-bit coarse setpoint in bits 5:0, reset zero, is the static value or the search start.
`timescale 1ns/1ps
module dll_clock_ctrl #(
	parameter int SETTLE_CYCLES = dll_ctrl_pkg::SETTLE_CYCLES_DEFAULT,
	parameter logic [7:0] FINE_STATIC = dll_ctrl_pkg::FINE_STATIC_DEFAULT
) (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Register port
	input wire logic [dll_ctrl_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dll_ctrl_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dll_ctrl_pkg::DATA_W-1:0] reg_rdata,
	// Phase detector from the delay line, asynchronous
	input wire logic phase_lags_in,
	// Analog controls
	output logic [dll_ctrl_pkg::HYS_W-1:0] receiver_hysteresis_amount,
	output logic loop_and_clockgen_powerdown,
	output logic fine_line_duty_correct_on,
	output logic fine_line_cross_ctrl_on,
	output logic coarse_line_duty_correct_on,
	output logic coarse_line_cross_ctrl_on,
	output logic [5:0] coarse_delay_code,
	output logic [7:0] fine_delay_code,
	// Status and interrupt
	output logic lock_achieved_flag,
	output logic irq
);
	import dll_ctrl_pkg::*;

	// ==============================================
	// Elaboration checks
	localparam int SETTLE_W = 12;

	generate
		if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << SETTLE_W)) begin : g_bad_settle
			$error("SETTLE_CYCLES out of range");
		end
		// The register map packs fields into byte-wide words and a ten-bit hysteresis code
		if (DATA_W != 8 || HYS_W != 10) begin : g_bad_width
			$error("register layout needs DATA_W 8 and HYS_W 10");
		end
	endgenerate

	localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES - 1);

	// ==============================================
	// State
	typedef struct packed {
		// Software registers
		logic [1:0] hys_hi;
		logic [7:0] hys_lo;
		logic [4:0] pwr;
		logic [7:0] ctrl;
		logic [3:0] guard;
		logic [5:0] coarse_sp;
		// Status, interrupt and read data
		logic locked;
		logic lost;
		logic fail;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic [7:0] rdata;
		// Controller
		loop_state_e st;
		logic [5:0] coarse;
		logic [7:0] fine;
		logic dir_up;
		logic last_need;
		logic first;
		logic [SETTLE_W-1:0] timer;
	} ctrl_s;

	ctrl_s cur_r;
	ctrl_s cur_nxt;

	logic phase_lags_s;
	logic loop_on;
	logic [1:0] mode;
	logic [1:0] search_dir;
	logic slope_pos;
	logic stop_on_search_err;
	logic stop_on_track_err;
	logic need_more;
	logic [5:0] lo_lim;
	logic [5:0] hi_lim;
	logic [2:0] ev;
	logic [2:0] irq_clr;
	logic lost_clr;
	// Controller helpers
	logic up_leg_allowed;
	logic decide;
	logic crossed;
	logic fine_stuck;
	logic [5:0] start_point;

	// ==============================================
	// Input synchroniser for the phase detector
	dll_sync2 #(
		.WIDTH(1)
	) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.async_in(phase_lags_in),
		.sync_out(phase_lags_s)
	);

	// ==============================================
	// Register read decode
	function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a, input ctrl_s s);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			ADDR_HYS_HI: v = {6'h00, s.hys_hi};
			ADDR_HYS_LO: v = s.hys_lo;
			ADDR_PWR: v = {3'h0, s.pwr};
			ADDR_CTRL: v = s.ctrl;
			ADDR_STAT: v = {5'h00, s.fail, s.lost, s.locked};
			ADDR_GUARD: v = {4'h0, s.guard};
			ADDR_COARSE: v = {2'h0, s.coarse_sp};
			ADDR_IRQ_STAT: v = {5'h00, s.irq_stat};
			ADDR_IRQ_MASK: v = {5'h00, s.irq_mask};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ==============================================
	// Clamp a coarse code into the guarded search window
	function automatic logic [5:0] clamp_coarse(input logic [5:0] v, input logic [5:0] lo, input logic [5:0] hi);
		logic [5:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	// Write strobe aimed at one address, shared by the write-one-to-clear decodes
	function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
		return wr && a == target;
	endfunction

	// ==============================================
	// Decoded control fields
	assign loop_on = cur_r.ctrl[CTRL_ENABLE_BIT] && !cur_r.pwr[PWR_PD_BIT];
	assign mode = cur_r.ctrl[CTRL_MODE_LSB +: 2];
	assign search_dir = cur_r.ctrl[CTRL_SEARCH_LSB +: 2];
	assign slope_pos = cur_r.ctrl[CTRL_SLOPE_BIT];
	assign stop_on_search_err = cur_r.ctrl[CTRL_SEARCH_ERR_BIT];
	assign stop_on_track_err = cur_r.ctrl[CTRL_TRACK_ERR_BIT];
	// A lagging output needs less delay on a positive slope
	assign need_more = slope_pos ? !phase_lags_s : phase_lags_s;
	// Guard band trims both ends of the coarse search range
	assign lo_lim = {2'h0, cur_r.guard};
	assign hi_lim = COARSE_MAX - {2'h0, cur_r.guard};

	// Software clears of sticky bits, write one to clear
	assign irq_clr = wr_hit(reg_wr, reg_addr, ADDR_IRQ_STAT) ? reg_wdata[2:0] : 3'h0;
	assign lost_clr = wr_hit(reg_wr, reg_addr, ADDR_STAT) && reg_wdata[STAT_LOST_BIT];

	// ==============================================
	// Controller decisions
	// Up leg only when both directions are asked for and room is left above the start
	assign up_leg_allowed = search_dir == SEARCH_BOTH && cur_r.coarse_sp < hi_lim;
	// One decision per settle period, once the delay line has had time to settle
	assign decide = cur_r.timer == '0;
	// A sign change between two decisions marks the lock point
	assign crossed = !cur_r.first && need_more != cur_r.last_need;
	// Fine line at a rail in the direction it must move, so lock cannot be held
	assign fine_stuck = (need_more && cur_r.fine == FINE_MAX) || (!need_more && cur_r.fine == FINE_MIN);
	// Search start, kept inside the guarded range
	assign start_point = clamp_coarse(cur_r.coarse_sp, lo_lim, hi_lim);

	// ==============================================
	// Next state
	always_comb begin
		cur_nxt = cur_r;
		ev = 3'h0;

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_HYS_HI: cur_nxt.hys_hi = reg_wdata[1:0];
				ADDR_HYS_LO: cur_nxt.hys_lo = reg_wdata;
				ADDR_PWR: cur_nxt.pwr = reg_wdata[4:0];
				ADDR_CTRL: cur_nxt.ctrl = reg_wdata;
				ADDR_GUARD: cur_nxt.guard = reg_wdata[3:0];
				ADDR_COARSE: cur_nxt.coarse_sp = reg_wdata[5:0];
				ADDR_IRQ_MASK: cur_nxt.irq_mask = reg_wdata[2:0];
				default: ; // Unmapped and read-only addresses take no write
			endcase
		end

		// Read data stand for one cycle only
		cur_nxt.rdata = reg_rd ? reg_read(reg_addr, cur_r) : 8'h00;

		// Controller
		if (!loop_on) begin
			// Static setpoints while disabled or powered down
			cur_nxt.st = LS_IDLE;
			cur_nxt.coarse = cur_r.coarse_sp;
			cur_nxt.fine = FINE_STATIC;
			cur_nxt.locked = 1'b0;
			cur_nxt.fail = 1'b0;
			cur_nxt.first = 1'b1;
			cur_nxt.dir_up = 1'b0;
			cur_nxt.timer = SETTLE_LOAD;
		end else begin
			unique case (cur_r.st)
				LS_IDLE: begin
					// Start from the coarse setpoint, clamped into the guarded range
					cur_nxt.coarse = start_point;
					cur_nxt.timer = SETTLE_LOAD;
					cur_nxt.first = 1'b1;
					cur_nxt.dir_up = 1'b0;
					cur_nxt.st = (mode == MODE_TRACK_ONLY) ? LS_TRACK : LS_SETTLE;
				end
				LS_SETTLE: begin
					if (!decide) begin
						cur_nxt.timer = cur_r.timer - 1'b1;
					end else begin
						cur_nxt.timer = SETTLE_LOAD;
						cur_nxt.last_need = need_more;
						cur_nxt.first = 1'b0;
						if (crossed) begin
							// Phase crossed between two steps: lock point found
							cur_nxt.locked = 1'b1;
							ev[IRQ_LOCK_BIT] = 1'b1;
							cur_nxt.st = (mode == MODE_SEARCH_ONLY) ? LS_HOLD : LS_TRACK;
						end else if (!cur_r.dir_up && cur_r.coarse > lo_lim) begin
							cur_nxt.coarse = cur_r.coarse - 6'h01;
						end else if (!cur_r.dir_up && up_leg_allowed) begin
							// Down leg exhausted, restart upward from the start point
							cur_nxt.dir_up = 1'b1;
							cur_nxt.first = 1'b1;
							cur_nxt.coarse = clamp_coarse(cur_r.coarse_sp + 6'h01, lo_lim, hi_lim);
						end else if (cur_r.dir_up && cur_r.coarse < hi_lim) begin
							cur_nxt.coarse = cur_r.coarse + 6'h01;
						end else begin
							// Range exhausted without a crossing
							cur_nxt.fail = 1'b1;
							ev[IRQ_FAIL_BIT] = 1'b1;
							cur_nxt.st = stop_on_search_err ? LS_HALT : LS_IDLE;
						end
					end
				end
				LS_TRACK: begin
					if (!decide) begin
						cur_nxt.timer = cur_r.timer - 1'b1;
					end else begin
						cur_nxt.timer = SETTLE_LOAD;
						cur_nxt.first = 1'b0;
						cur_nxt.last_need = need_more;
						// Track only declares lock once the phase dithers
						if (mode == MODE_TRACK_ONLY && !cur_r.locked && crossed) begin
							cur_nxt.locked = 1'b1;
							ev[IRQ_LOCK_BIT] = 1'b1;
						end
						if (fine_stuck) begin
							// Fine line out of range: lock cannot be held
							if (cur_r.locked) begin
								cur_nxt.locked = 1'b0;
								ev[IRQ_LOST_BIT] = 1'b1;
							end
							if (stop_on_track_err) begin
								cur_nxt.st = LS_HALT;
							end
						end else if (need_more) begin
							cur_nxt.fine = cur_r.fine + 8'h01;
						end else begin
							cur_nxt.fine = cur_r.fine - 8'h01;
						end
					end
				end
				LS_HOLD: begin
					// Search only keeps the found point
					cur_nxt.st = LS_HOLD;
				end
				LS_HALT: begin
					// Stopped on error until software disables the loop
					cur_nxt.st = LS_HALT;
				end
				default: cur_nxt.st = LS_IDLE;
			endcase
		end

		// Sticky flags: a new event wins over a clear in the same cycle
		cur_nxt.lost = (cur_r.lost && !lost_clr) || ev[IRQ_LOST_BIT];
		cur_nxt.irq_stat = (cur_r.irq_stat & ~irq_clr) | ev;
	end

	// ==============================================
	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cur_r <= '0;
			cur_r.pwr <= PWR_RST;
			cur_r.ctrl <= CTRL_RST;
			cur_r.st <= LS_IDLE;
			cur_r.fine <= FINE_STATIC;
			cur_r.first <= 1'b1;
			cur_r.timer <= SETTLE_LOAD;
		end else if (clk_en) begin
			cur_r <= cur_nxt;
		end
	end

	// ==============================================
	// Outputs, all from flops
	assign reg_rdata = cur_r.rdata;
	assign receiver_hysteresis_amount = {cur_r.hys_hi, cur_r.hys_lo};
	assign loop_and_clockgen_powerdown = cur_r.pwr[PWR_PD_BIT];
	assign fine_line_duty_correct_on = cur_r.pwr[FINE_DC_BIT];
	assign coarse_line_duty_correct_on = cur_r.pwr[COARSE_DC_BIT];
	assign fine_line_cross_ctrl_on = cur_r.pwr[FINE_XC_BIT];
	assign coarse_line_cross_ctrl_on = cur_r.pwr[COARSE_XC_BIT];
	assign coarse_delay_code = cur_r.coarse;
	assign fine_delay_code = cur_r.fine;
	assign lock_achieved_flag = cur_r.locked;
	// Level interrupt, high while any unmasked sticky bit is set
	assign irq = |(cur_r.irq_stat & cur_r.irq_mask);

endmodule

// *** test/dll_clock_ctrl_checker.sv ***
// Port-level assertions for the delay loop controller
`timescale 1ns/1ps
module dll_clock_ctrl_checker #(
	parameter logic [7:0] FINE_STATIC = dll_ctrl_pkg::FINE_STATIC_DEFAULT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Register port
	input wire logic [dll_ctrl_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dll_ctrl_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [dll_ctrl_pkg::DATA_W-1:0] reg_rdata,
	// Analog controls and status
	input wire logic [dll_ctrl_pkg::HYS_W-1:0] receiver_hysteresis_amount,
	input wire logic loop_and_clockgen_powerdown,
	input wire logic fine_line_duty_correct_on,
	input wire logic fine_line_cross_ctrl_on,
	input wire logic coarse_line_duty_correct_on,
	input wire logic coarse_line_cross_ctrl_on,
	input wire logic [5:0] coarse_delay_code,
	input wire logic [7:0] fine_delay_code,
	input wire logic lock_achieved_flag
);
	import dll_ctrl_pkg::*;
	logic en_r;
	// Shadow of the controller enable, since the body is out of reach
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			en_r <= 1'b0;
		end else if (clk_en && reg_wr && reg_addr == ADDR_CTRL) begin
			en_r <= reg_wdata[CTRL_ENABLE_BIT];
		end
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// ==========
	// Steps of a write
	sequence s_wr_pwr;
		clk_en && reg_wr && reg_addr == ADDR_PWR;
	endsequence
	sequence s_wr_coarse;
		clk_en && reg_wr && reg_addr == ADDR_COARSE && !en_r;
	endsequence
	sequence s_quiet;
		(clk_en && !reg_wr) [*2];
	endsequence
	// ==========
	// Assertions
	a_rdata_one_cycle: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
		else $error("read data outside its cycle");
	a_hys_low: assert property (clk_en && reg_wr && reg_addr == ADDR_HYS_LO |=>
		receiver_hysteresis_amount[7:0] == $past(reg_wdata)) else $error("hysteresis low bits wrong");
	a_hys_high: assert property (clk_en && reg_wr && reg_addr == ADDR_HYS_HI |=>
		receiver_hysteresis_amount[9:8] == $past(reg_wdata[1:0])) else $error("hysteresis high bits wrong");
	a_pd_follows: assert property (s_wr_pwr |=>
		loop_and_clockgen_powerdown == $past(reg_wdata[PWR_PD_BIT])) else $error("powerdown wrong");
	a_duty_follows: assert property (s_wr_pwr |=> fine_line_duty_correct_on == $past(reg_wdata[FINE_DC_BIT])
		&& coarse_line_duty_correct_on == $past(reg_wdata[COARSE_DC_BIT])) else $error("duty enables wrong");
	a_cross_follows: assert property (s_wr_pwr |=> fine_line_cross_ctrl_on == $past(reg_wdata[FINE_XC_BIT])
		&& coarse_line_cross_ctrl_on == $past(reg_wdata[COARSE_XC_BIT])) else $error("cross enables wrong");
	a_static_hold: assert property (!en_r [*4] |->
		fine_delay_code == FINE_STATIC && !lock_achieved_flag) else $error("static setpoint not held");
	a_coarse_static: assert property (s_wr_coarse ##1 s_quiet |=>
		coarse_delay_code == $past(reg_wdata[5:0], 3)) else $error("coarse setpoint not applied");
endmodule

bind dll_clock_ctrl dll_clock_ctrl_checker #(.FINE_STATIC(FINE_STATIC)) u_chk (
	.ref_clk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.receiver_hysteresis_amount, .loop_and_clockgen_powerdown, .fine_line_duty_correct_on,
	.fine_line_cross_ctrl_on, .coarse_line_duty_correct_on, .coarse_line_cross_ctrl_on,
	.coarse_delay_code, .fine_delay_code, .lock_achieved_flag
);

// *** test/dll_clock_ctrl_test.sv ***
// Self-checking bench for the delay loop controller
`timescale 1ns/1ps
module dll_clock_ctrl_test;
	import dll_ctrl_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic phase_lags_in = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [HYS_W-1:0] receiver_hysteresis_amount;
	logic loop_and_clockgen_powerdown, fine_line_duty_correct_on, fine_line_cross_ctrl_on;
	logic coarse_line_duty_correct_on, coarse_line_cross_ctrl_on, lock_achieved_flag, irq, bad;
	logic [5:0] coarse_delay_code;
	logic [7:0] fine_delay_code, d;
	logic [7:0] exp_q[$];
	logic [7:0] last[6];
	logic rd_seen = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int i;
	integer seed = 32'h13cd_c811;
	logic [ADDR_W-1:0] rst_a[10] = '{ADDR_HYS_HI, ADDR_HYS_LO, ADDR_PWR, ADDR_CTRL, ADDR_GUARD,
		ADDR_COARSE, ADDR_STAT, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 12'h0FF};
	logic [7:0] rst_v[10] = '{8'h00, 8'h00, 8'h1F, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] rw_m[6] = '{8'h03, 8'hFF, 8'h1F, 8'hFE, 8'h0F, 8'h3F};
	// Track only, search only, search then track; the last one runs on to a loss
	logic [7:0] modes[3] = '{8'hF3, 8'hF5, 8'hF1};

	// Short settle count keeps the searches within a few hundred cycles
	dll_clock_ctrl #(.SETTLE_CYCLES(2)) dut (
		.ref_clk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phase_lags_in,
		.receiver_hysteresis_amount, .loop_and_clockgen_powerdown, .fine_line_duty_correct_on,
		.fine_line_cross_ctrl_on, .coarse_line_duty_correct_on, .coarse_line_cross_ctrl_on,
		.coarse_delay_code, .fine_delay_code, .lock_achieved_flag, .irq
	);

	// ==========
	// Shared tasks
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// The expected value is noted when the strobe goes out
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Clock
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Read data land one cycle after a taken strobe; also the hang limit
	always @(posedge ref_clk) begin
		cyc++;
		if (rd_seen) begin
			check("reg_rdata", reg_rdata, exp_q.pop_front());
		end
		rd_seen = reg_rd && clk_en;
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	// ==========
	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		check("controls", {fine_line_duty_correct_on, fine_line_cross_ctrl_on, coarse_line_duty_correct_on,
			coarse_line_cross_ctrl_on, loop_and_clockgen_powerdown}, 5'h1F);
		check("fine", fine_delay_code, FINE_STATIC_DEFAULT);
		check("lock_coarse", {irq, lock_achieved_flag, coarse_delay_code}, 8'h00);
		check("hys", receiver_hysteresis_amount, 10'h000);
		// Frozen port, read-only status and unmapped writes must leave reset values
		clk_en <= 1'b0;
		wr(ADDR_PWR, 8'h00);
		clk_en <= 1'b1;
		wr(ADDR_STAT, 8'hFF);
		wr(12'h0FF, 8'hFF);
		for (i = 0; i < 10; i++) begin
			rd(rst_a[i], rst_v[i]);
		end
		// Random readback; enable kept low so the setpoints stay static
		for (i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			if (rst_a[i] == ADDR_CTRL) d[CTRL_ENABLE_BIT] = 1'b0;
			last[i] = d & rw_m[i];
			wr(rst_a[i], d);
			rd(rst_a[i], last[i]);
		end
		check("hys", receiver_hysteresis_amount, {last[0][1:0], last[1]});
		wr(ADDR_GUARD, 8'h02);
		wr(ADDR_COARSE, 8'h0A);
		wr(ADDR_PWR, 8'h1E);
		wr(ADDR_IRQ_MASK, 8'h02);
		// Lock once in every mode: steady phase, then a sign change
		foreach (modes[m]) begin
			wr(ADDR_CTRL, 8'hF0);
			wr(ADDR_IRQ_STAT, 8'h07);
			phase_lags_in <= 1'b0;
			wr(ADDR_CTRL, modes[m]);
			repeat (12) @(posedge ref_clk);
			phase_lags_in <= 1'b1;
			for (i = 0; i < 500 && lock_achieved_flag !== 1'b1; i++) @(posedge ref_clk);
			check("lock", lock_achieved_flag, 1'b1);
		end
		// Tracking runs fine down to zero and loses the lock
		for (i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge ref_clk);
		check("lost", {irq, lock_achieved_flag, fine_delay_code}, {2'b10, FINE_MIN});
		rd(ADDR_STAT, 8'h02);
		rd(ADDR_IRQ_STAT, 8'h03);
		wr(ADDR_STAT, 8'h02);
		rd(ADDR_STAT, 8'h00);
		wr(ADDR_IRQ_STAT, 8'h02);
		@(posedge ref_clk);
		check("irq_clear", irq, 1'b0);
		// Down-only search with a steady phase must fail without going up
		wr(ADDR_CTRL, 8'hF4);
		wr(ADDR_IRQ_MASK, 8'h04);
		phase_lags_in <= 1'b0;
		wr(ADDR_CTRL, 8'hE5);
		bad = 1'b0;
		for (i = 0; i < 1000 && irq !== 1'b1; i++) begin
			@(posedge ref_clk);
			bad = bad | (coarse_delay_code > 6'h0A);
		end
		check("down_only", bad, 1'b0);
		check("fail_irq", irq, 1'b1);
		check("guard_floor", coarse_delay_code, 6'h02);
		rd(ADDR_STAT, 8'h04);
		wr(ADDR_IRQ_MASK, 8'h00);
		@(posedge ref_clk);
		check("masked", irq, 1'b0);
		print_verdict();
	end
endmodule
